// [core/mrx_insn_exec.v]
// Purpose: Decode and execute a move/or/return subset of a 14-bit ISA
// Assumes: Instruction words arrive with a valid strobe, synchronous to mclk_in
// Notes:   Other opcodes are accepted and retire as one-cycle no-ops
//
// Overview of operation
// - Move working to file, flags kept, one cycle
// - OR literal into working, zero flag updated
// - OR working with file, d selects destination
// - Load literal to working, ignore don't-care bits
// - Return from interrupt: pop stack, set enable
// - Return with literal: load working, pop stack
`timescale 1ns/100ps
`default_nettype none
`include "mrx_consts.vh"

module mrx_insn_exec (
    input  wire                     mclk_in,         // Core clock, 100 MHz
    input  wire                     sys_rst_in,      // Sync reset, active high
    input  wire [`MRX_INSN_W-1:0]   insn_in,         // Instruction word
    input  wire                     insn_valid_in,   // Instruction word valid
    input  wire [`MRX_PC_W-1:0]     top_of_stack_in, // Top-of-stack return address
    input  wire                     ie_clear_in,     // Interrupt entry clears enable
    output reg                      ready_out,       // Will take a word this cycle
    output reg                      retire_out,      // Pulse: instruction executed
    output reg  [`MRX_DATA_W-1:0]   working_out,     // Working register
    output reg                      zero_flag_out,   // Zero status flag
    output reg  [`MRX_DATA_W-1:0]   icr_out,         // Interrupt control register
    output reg                      pc_load_out,     // Pulse: load program counter
    output reg  [`MRX_PC_W-1:0]     pc_out,          // New program counter value
    output reg                      stack_pop_out,   // Pulse: pop hardware stack
    output reg                      file_wr_out,     // Pulse: file register written
    output reg  [`MRX_ADDR_W-1:0]   file_addr_out,   // Address of that write
    output reg  [`MRX_DATA_W-1:0]   file_data_out    // Data of that write
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam [1:0] ST_EXEC  = 2'b01;
    localparam [1:0] ST_FLUSH = 2'b10;

    reg  [1:0]              state_q;
    reg  [1:0]              state_d;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire                    take;
    wire                    is_move_file;
    wire                    is_or_lit;
    wire                    is_or_file;
    wire                    is_load_lit;
    wire                    is_ret_int;
    wire                    is_ret_lit;
    wire                    is_return;
    wire [`MRX_ADDR_W-1:0]  f_addr;
    wire [`MRX_DATA_W-1:0]  literal;
    wire                    dest_file;
    wire [`MRX_DATA_W-1:0]  file_rd;
    wire [`MRX_DATA_W-1:0]  or_src;
    wire [`MRX_DATA_W-1:0]  or_res;
    wire [`MRX_DATA_W:0]    nonzero_chain;
    wire                    or_zero;
    wire                    bank_we;
    wire [`MRX_DATA_W-1:0]  bank_wd;

    // A word shown while the sequencer flushes is dropped and must be shown again
    assign take         = insn_valid_in & ready_out & state_q[0];
    assign is_move_file = (insn_in & `MRX_MASK_MOVE_FILE) == `MRX_VAL_MOVE_FILE;
    assign is_or_lit    = (insn_in & `MRX_MASK_OP6) == `MRX_VAL_OR_LITERAL;
    assign is_or_file   = (insn_in & `MRX_MASK_OP6) == `MRX_VAL_OR_FILE;
    // Bits 9:8 are masked out so any of the four don't-care patterns decodes
    assign is_load_lit  = (insn_in & `MRX_MASK_OP4) == `MRX_VAL_LOAD_LITERAL;
    assign is_ret_lit   = (insn_in & `MRX_MASK_OP4) == `MRX_VAL_RETURN_LITERAL;
    assign is_ret_int   = (insn_in & `MRX_MASK_ALL) == `MRX_VAL_RETURN_INTERRUPT;
    assign is_return    = is_ret_int | is_ret_lit;
    assign f_addr       = insn_in[`MRX_ADDR_W-1:0];
    assign literal      = insn_in[`MRX_DATA_W-1:0];
    assign dest_file    = insn_in[`MRX_DEST_BIT];

    // ****************************************************************
    // OR unit and zero detect, one slice per data bit
    // ****************************************************************
    assign or_src           = is_or_lit ? literal : file_rd;
    assign nonzero_chain[0] = 1'b0;

    genvar b;
    generate
        for (b = 0; b < `MRX_DATA_W; b = b + 1) begin : g_or_bit
            assign or_res[b]          = working_out[b] | or_src[b];
            assign nonzero_chain[b+1] = nonzero_chain[b] | or_res[b];
        end
    endgenerate

    // Ripple chain is only eight gates deep, well inside one cycle
    assign or_zero = ~nonzero_chain[`MRX_DATA_W];

    // A write lands on the taking edge; the read above still sees the old contents
    assign bank_we = take & (is_move_file | (is_or_file & dest_file));
    assign bank_wd = is_move_file ? working_out : or_res;

    // ****************************************************************
    // File registers
    // ****************************************************************
    mrx_file_bank u_bank (
        .mclk_in     (mclk_in),
        .wr_en_in    (bank_we),
        .wr_addr_in  (f_addr),
        .wr_data_in  (bank_wd),
        .rd_addr_in  (f_addr),
        .rd_data_out (file_rd)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_EXEC: begin
                // Returns spend their second cycle discarding the prefetched word
                if (take && is_return) begin
                    state_d = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                state_d = ST_EXEC;
            end
            default: begin
                state_d = ST_EXEC;
            end
        endcase
    end

    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_q   <= ST_EXEC;
            ready_out <= 1'b0;
        end else begin
            state_q   <= state_d;
            ready_out <= state_d[0];
        end
    end

    // ****************************************************************
    // Execute: next values
    // ****************************************************************
    reg  [`MRX_DATA_W-1:0]  working_d;
    reg                     zero_flag_d;
    reg                     ie_d;
    reg  [`MRX_PC_W-1:0]    pc_d;
    reg                     pc_load_d;
    reg                     stack_pop_d;
    reg  [`MRX_ADDR_W-1:0]  file_addr_d;
    reg  [`MRX_DATA_W-1:0]  file_data_d;

    always @* begin
        // Values hold and pulses drop unless the word taken this cycle or an enable clear says otherwise
        working_d   = working_out;
        zero_flag_d = zero_flag_out;
        ie_d        = icr_out[`MRX_GLOBAL_IE_BIT];
        pc_d        = pc_out;
        pc_load_d   = 1'b0;
        stack_pop_d = 1'b0;
        file_addr_d = file_addr_out;
        file_data_d = file_data_out;
        if (take && (is_or_lit || (is_or_file && !dest_file))) begin
            working_d = or_res;
        end
        // Only the two OR forms touch the zero flag; moves and returns keep it
        if (take && (is_or_lit || is_or_file)) begin
            zero_flag_d = or_zero;
        end
        if (take && (is_load_lit || is_ret_lit)) begin
            working_d = literal;
        end
        if (take && is_return) begin
            pc_d        = top_of_stack_in;
            pc_load_d   = 1'b1;
            stack_pop_d = 1'b1;
        end
        // Address and data hold after the pulse so a slow observer can still read them
        if (bank_we) begin
            file_addr_d = f_addr;
            file_data_d = bank_wd;
        end
        // Return from interrupt and interrupt-entry clear in one cycle: the return wins
        if (take && is_ret_int) begin
            ie_d = 1'b1;
        end else if (ie_clear_in) begin
            ie_d = 1'b0;
        end
    end

    // ****************************************************************
    // Execute: registers
    // ****************************************************************
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            retire_out    <= 1'b0;
            working_out   <= `MRX_RST_DATA;
            zero_flag_out <= 1'b0;
            icr_out       <= `MRX_RST_ICR;
            pc_load_out   <= 1'b0;
            pc_out        <= `MRX_RST_PC;
            stack_pop_out <= 1'b0;
            file_wr_out   <= 1'b0;
            file_addr_out <= {`MRX_ADDR_W{1'b0}};
            file_data_out <= `MRX_RST_DATA;
        end else begin
            retire_out    <= take;
            working_out   <= working_d;
            zero_flag_out <= zero_flag_d;
            icr_out[`MRX_GLOBAL_IE_BIT] <= ie_d;
            pc_load_out   <= pc_load_d;
            pc_out        <= pc_d;
            stack_pop_out <= stack_pop_d;
            file_wr_out   <= bank_we;
            file_addr_out <= file_addr_d;
            file_data_out <= file_data_d;
        end
    end

endmodule
`default_nettype wire

// [core/mrx_consts.vh]
// Purpose: Shared constants for the move/or/return execute unit
// Assumes: 14-bit instruction words, 8-bit data, 13-bit program counter
// Notes:   Definitions only
`ifndef MRX_CONSTS_VH
`define MRX_CONSTS_VH

// ****************************************************************
// Widths and fields
// ****************************************************************
`define MRX_INSN_W        14
`define MRX_DATA_W        8
`define MRX_ADDR_W        7
`define MRX_PC_W          13
`define MRX_FILE_DEPTH    128
`define MRX_DEST_BIT      7
`define MRX_GLOBAL_IE_BIT 7

// ****************************************************************
// Opcode masks and match values
// ****************************************************************
`define MRX_MASK_MOVE_FILE       14'h3F80
`define MRX_VAL_MOVE_FILE        14'h0080
`define MRX_MASK_OP6             14'h3F00
`define MRX_VAL_OR_LITERAL       14'h3800
`define MRX_VAL_OR_FILE          14'h0400
`define MRX_MASK_OP4             14'h3C00
`define MRX_VAL_LOAD_LITERAL     14'h3000
`define MRX_VAL_RETURN_LITERAL   14'h3400
`define MRX_MASK_ALL             14'h3FFF
`define MRX_VAL_RETURN_INTERRUPT 14'h0009

// ****************************************************************
// Reset values
// ****************************************************************
`define MRX_RST_DATA      8'h00
`define MRX_RST_PC        13'h0000
`define MRX_RST_ICR       8'h00
`define MRX_ZERO_DATA     8'h00

`endif

// [core/mrx_file_bank.v]
// Purpose: 128-entry file register array, async read, sync write
// Assumes: One write port, one read port, clock mclk_in
// Notes:   Contents are not reset, as in a real register file
`timescale 1ns/100ps
`default_nettype none
`include "mrx_consts.vh"

module mrx_file_bank (
    input  wire                     mclk_in,     // Core clock
    input  wire                     wr_en_in,    // Write strobe
    input  wire [`MRX_ADDR_W-1:0]   wr_addr_in,  // Write address
    input  wire [`MRX_DATA_W-1:0]   wr_data_in,  // Write data
    input  wire [`MRX_ADDR_W-1:0]   rd_addr_in,  // Read address
    output wire [`MRX_DATA_W-1:0]   rd_data_out  // Read data, same cycle
);

    reg [`MRX_DATA_W-1:0] mem_q [0:`MRX_FILE_DEPTH-1];

    always @(posedge mclk_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
    end

    assign rd_data_out = mem_q[rd_addr_in];

endmodule
`default_nettype wire

// [tb/mrx_insn_exec_monitor.sv]
// Purpose: Port-level checks of the execute unit
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every execute unit instance
`timescale 1ns/100ps
`default_nettype none
module mrx_insn_exec_monitor (
    input wire logic        mclk_in,         // Core clock
    input wire logic        sys_rst_in,      // Sync reset, active high
    input wire logic        insn_valid_in,   // Word valid
    input wire logic        ie_clear_in,     // Enable clear request
    input wire logic [13:0] insn_in,         // Instruction word
    input wire logic [12:0] top_of_stack_in, // Return address
    input wire logic [12:0] pc_out,          // Loaded program counter
    input wire logic        ready_out,       // Unit can take a word
    input wire logic        retire_out,      // Retire pulse
    input wire logic        zero_flag_out,   // Zero flag
    input wire logic        pc_load_out,     // Counter load pulse
    input wire logic        stack_pop_out,   // Stack pop pulse
    input wire logic        file_wr_out,     // File write pulse
    input wire logic [7:0]  working_out,     // Working register
    input wire logic [7:0]  icr_out,         // Interrupt control register
    input wire logic [7:0]  file_data_out,   // Written data
    input wire logic [6:0]  file_addr_out    // Written address
);
    default clocking dc @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    wire logic take = insn_valid_in && ready_out;
    sequence ret_pulse; pc_load_out && stack_pop_out && retire_out && !ready_out; endsequence
    sequence ret_done; !pc_load_out && ready_out; endsequence
    move_file_a: assert property (take && insn_in[13:7] == 7'h01 |=>
        file_wr_out && file_data_out == $past(working_out) && $stable(zero_flag_out)
        && file_addr_out == $past(insn_in[6:0])) else $error("move to file wrong");
    retire_pulse_a: assert property (retire_out == $past(take))
        else $error("retire pulse wrong");
    or_literal_a: assert property (take && insn_in[13:8] == 6'h38 |=>
        working_out == ($past(working_out) | $past(insn_in[7:0]))
        && zero_flag_out == (working_out == 8'h00)) else $error("or literal wrong");
    or_file_a: assert property (take && insn_in[13:8] == 6'h04 |=>
        file_wr_out == $past(insn_in[7]) && ($past(insn_in[7]) ? working_out == $past(working_out)
        && zero_flag_out == (file_data_out == 8'h00) : zero_flag_out == (working_out == 8'h00)))
        else $error("or file wrong");
    load_literal_a: assert property (take && insn_in[13:10] == 4'hC |=>
        working_out == $past(insn_in[7:0]) && $stable(zero_flag_out)) else $error("load wrong");
    ret_int_a: assert property (take && insn_in == 14'h0009 |=> ret_pulse ##0
        (icr_out[7] && pc_out == $past(top_of_stack_in) && $stable(zero_flag_out)) ##1 ret_done)
        else $error("return from interrupt wrong");
    ret_lit_a: assert property (take && insn_in[13:10] == 4'hD |=> ret_pulse ##0
        (working_out == $past(insn_in[7:0]) && pc_out == $past(top_of_stack_in)
        && $stable(zero_flag_out)) ##1 ret_done) else $error("return with literal wrong");
    lit_no_write_a: assert property (take && insn_in[13:12] == 2'h3 |=>
        !file_wr_out) else $error("literal op wrote a file register");
    ie_clear_a: assert property (ie_clear_in && !(take && insn_in == 14'h0009) |=>
        !icr_out[7]) else $error("enable clear wrong");
endmodule
bind mrx_insn_exec mrx_insn_exec_monitor mon (.*);
`default_nettype wire

// [tb/mrx_prog_mem.sv]
// Purpose: Program memory model feeding instruction words
// Assumes: Word is held until taken with ready high
// Notes:   Idle bus inverts its previous value every cycle, starting from the last word
`timescale 1ns/100ps
`default_nettype none
module mrx_prog_mem (
    input  wire logic        mclk_in,   // Core clock
    input  wire logic        ready_in,  // Unit can take a word
    input  wire logic        stall_in,  // Memory slow this cycle
    output var  logic [13:0] insn_out,  // Word
    output var  logic        valid_out  // Word valid
);
    logic [13:0] q[$];
    initial begin
        insn_out = 14'h0000;
        valid_out = 1'b0;
    end
    always @(posedge mclk_in) if (valid_out && ready_in) void'(q.pop_front());
    always @(negedge mclk_in) begin
        valid_out <= q.size() != 0 && !stall_in;
        insn_out <= (q.size() != 0 && !stall_in) ? q[0] : ~insn_out;
    end
endmodule
`default_nettype wire

// [tb/move_or_return_insn_exec_tb_top.sv]
// Purpose: Random and directed run of the execute unit
// Assumes: 100 MHz clock, reset held three cycles
// Notes:   File addresses kept to 0..7 so all are written first
`timescale 1ns/100ps
`default_nettype none
module move_or_return_insn_exec_tb_top;
    logic mclk_in = 0, sys_rst_in = 1, ie_clr = 0, stall = 1, fw, ret, iex = 0;
    logic [12:0] stack_top = 13'h0000;
    logic [7:0] wx = 8'h00, fd, m[8];
    logic zx = 0;
    logic [13:0] insn, wq[$];
    logic [12:0] tq[$];
    wire logic valid, rdy, rtr, z, pld, pop, fwr;
    wire logic [7:0] w, icr, fdat;
    wire logic [12:0] pc;
    wire logic [6:0] fa;
    integer seed = 32'h038DD0AE, errors = 0, n_checks = 0, i;
    always #5 mclk_in = ~mclk_in;
    mrx_prog_mem pm (.mclk_in(mclk_in), .ready_in(rdy), .stall_in(stall), .insn_out(insn),
        .valid_out(valid));
    mrx_insn_exec uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .insn_in(insn),
        .insn_valid_in(valid), .top_of_stack_in(stack_top), .ie_clear_in(ie_clr),
        .ready_out(rdy),
        .retire_out(rtr), .working_out(w), .zero_flag_out(z), .icr_out(icr), .pc_load_out(pld),
        .pc_out(pc), .stack_pop_out(pop), .file_wr_out(fwr), .file_addr_out(fa),
        .file_data_out(fdat));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, s, e);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [13:0] rnd_word(input int k, input logic [9:0] v);
        case (k)
            0: return {7'h01, 4'h0, v[2:0]};
            1: return {6'h38, v[7:0]};
            2: return {6'h04, v[8], 4'h0, v[2:0]};
            3: return {4'hC, v[9:0]};
            4: return {4'hD, v[9:0]};
            5: return 14'h0009;
            default: return 14'h0000;
        endcase
    endfunction
    // Reference step per retired word, checked while the outputs are settled
    task automatic step(input logic [13:0] wd, input logic [12:0] t);
        fw = 0;
        ret = 0;
        fd = wx | m[wd[2:0]];
        casez (wd)
            14'b00_0000_1???????: begin fw = 1; fd = wx; end
            14'b11_1000_????????: begin wx = wx | wd[7:0]; zx = wx == 8'h00; end
            14'b00_0100_0???????: begin wx = fd; zx = fd == 8'h00; end
            14'b00_0100_1???????: begin fw = 1; zx = fd == 8'h00; end
            14'b11_00??_????????: wx = wd[7:0];
            14'b11_01??_????????: begin wx = wd[7:0]; ret = 1; end
            14'h0009: ret = 1;
            default: ;
        endcase
        if (fw) m[wd[2:0]] = fd;
        chk(w, wx);
        chk(z, zx);
        chk(fwr, fw);
        if (fw) chk({fa, fdat}, {wd[6:0], fd});
        chk({pld, pop, rdy}, {ret, ret, !ret});
        if (ret) chk(pc, t);
        if (wd == 14'h0009) chk(icr[7], 1);
    endtask
    always @(posedge mclk_in) if (valid && rdy) begin
        wq.push_back(insn);
        tq.push_back(stack_top);
    end
    // Enable bit model: a taken return from interrupt sets it and beats a clear
    always @(posedge mclk_in) begin
        if (sys_rst_in) iex <= 0;
        else if (valid && rdy && insn == 14'h0009) iex <= 1;
        else if (ie_clr) iex <= 0;
    end
    always @(negedge mclk_in) if (!sys_rst_in) chk(icr, {iex, 7'h00});
    always @(negedge mclk_in) if (rtr) begin
        if (wq.size() == 0) chk(0, 1);
        else step(wq.pop_front(), tq.pop_front());
    end
    initial begin
        pm.q = '{14'h3300, 14'h3800};
        for (i = 0; i < 8; i++) pm.q.push_back({7'h01, 4'h0, i[2:0]});
        pm.q.push_back(14'h0009);
        pm.q.push_back(14'h3455);
        for (i = 0; i < 300; i++) pm.q.push_back(rnd_word($unsigned($random(seed)) % 7,
            10'($random(seed))));
        repeat (3) @(posedge mclk_in);
        @(negedge mclk_in) sys_rst_in = 0;
        for (i = 0; i < 5000 && (pm.q.size() != 0 || wq.size() != 0); i++) begin
            @(negedge mclk_in);
            stall <= i > 30 && $random(seed) % 4 == 0;
            stack_top <= 13'($random(seed));
            ie_clr <= $random(seed) % 5 == 0;
        end
        if (i == 5000) errors++;
        repeat (2) @(negedge mclk_in);
        test_done();
    end
endmodule
`default_nettype wire
